// ### rtl/olrv_top.sv
// Contract
// - Each of the three legs takes its own output table and drives its own converter path.
// - Exactly one leg routes its current to the load while the other two shunt to ground; all three shunt when no leg is healthy.
// - Every point is read back and all three legs check the delivered signal continuously.
// - Any failed diagnostic on any leg raises the fault indicator, which raises the alarm.
// - Legs cross-compare their values and confirm the driving leg delivers the expected value.
// - Loopback readings are self-calibrated for gain and offset from reference voltages.
// - A leg may drive the load only when at least two of the three legs vote it healthy.
// - Every 10 seconds the drive duty moves to the next healthy leg in one fixed direction.
// - The block tracks which leg drives the load and which leg is next in the rotation.
// - A leg failing its self-diagnosis is skipped and loses its right to vote.
// - A faulty driving leg is detected, voted out and replaced by a healthy leg within 20 ms.
// - A faulty or corrupt non-driving leg never disturbs the output.
`timescale 1ns/100ps
`default_nettype none

module olrv_top
#(
   parameter int unsigned ROT_CYCLES    = olrv_pkg::ROT_CYCLES,
   parameter int unsigned SAMPLE_CYCLES = olrv_pkg::SAMPLE_CYCLES
)
(
   // Clock and reset
   input  wire logic                                          CLOCK_I,
   input  wire logic                                          SRST_I,
   // Output tables, one per main processor leg
   input  wire olrv_pkg::olrv_tbl_wr_t [olrv_pkg::NLEG-1:0]   TABLE_WR_I,
   // Leg processor self-diagnosis result
   input  wire logic [olrv_pkg::NLEG-1:0]                     SELF_DIAG_OK_I,
   // Loopback converters, one per leg
   input  wire olrv_pkg::olrv_adc_t [olrv_pkg::NLEG-1:0]      ADC_I,
   output logic [olrv_pkg::NLEG-1:0][olrv_pkg::CHW-1:0]       MUX_SEL_O,
   // Converter codes and load switches
   output olrv_pkg::olrv_pts_t [olrv_pkg::NLEG-1:0]           DAC_CODE_O,
   output logic [olrv_pkg::NLEG-1:0]                          SWITCH_LOAD_O,
   // Rotation state
   output logic [olrv_pkg::LW-1:0]                            DRIVE_LEG_O,
   output logic                                               DRIVE_ON_O,
   output logic [olrv_pkg::LW-1:0]                            NEXT_LEG_O,
   output logic [olrv_pkg::NLEG-1:0]                          HEALTHY_O,
   // Fault indicator and chassis alarm
   output logic                                               FAULT_O,
   output logic                                               ALARM_O
);

   olrv_pkg::olrv_pts_t [olrv_pkg::NLEG-1:0]   tbl_q;
   olrv_pkg::olrv_pts_t [olrv_pkg::NLEG-1:0]   loop_w;
   logic [olrv_pkg::NLEG-1:0]                  cal_ok_w;
   logic [olrv_pkg::NLEG-1:0]                  seen_q;
   logic [olrv_pkg::NLEG-1:0]                  self_ok;
   logic [olrv_pkg::NLEG-1:0][olrv_pkg::NLEG-1:0] pair_ok;
   logic [olrv_pkg::NLEG-1:0]                  loop_ok;
   logic [olrv_pkg::NLEG-1:0]                  miss_bad;
   logic [olrv_pkg::NLEG-1:0][7:0]             miss_q;
   logic [olrv_pkg::NLEG-1:0]                  drv_fault_q;
   logic [olrv_pkg::NLEG-1:0]                  healthy;
   logic [olrv_pkg::LW-1:0]                    drv_q;
   logic [olrv_pkg::LW-1:0]                    drv_d;
   logic                                       drv_on_q;
   logic                                       drv_on_d;
   logic                                       drv_chg;
   logic [31:0]                                rot_q;
   logic [31:0]                                rot_d;
   logic [31:0]                                smp_q;
   logic                                       smp_tick;

   // Codes within a tolerance of each other
   function automatic logic near_fn(input logic [15:0] a,
                                    input logic [15:0] b,
                                    input logic [15:0] tol);
      near_fn = ((a > b) ? a - b : b - a) <= tol;
   endfunction : near_fn

   // First healthy leg after cur, in cyclic order A, B, C
   function automatic logic [1:0] nxt_fn(input logic [1:0] cur, input logic [2:0] ok);
      logic [1:0] c;
      c = cur;
      nxt_fn = cur;
      for (int k = 0; k < 3; k++)
      begin
         c = (c == 2'd2) ? 2'd0 : c + 2'd1;
         if (ok[c])
         begin
            nxt_fn = c;
            break;
         end
      end
   endfunction : nxt_fn

   // Per-leg loopback scan and calibration
   for (genvar g = 0; g < olrv_pkg::NLEG; g++)
   begin : g_leg
      olrv_leg_mon u_mon
      (
         .clk_i     (CLOCK_I),
         .srst_i    (SRST_I),
         .adc_i     (ADC_I[g]),
         .mux_sel_o (MUX_SEL_O[g]),
         .loop_o    (loop_w[g]),
         .cal_ok_o  (cal_ok_w[g])
      );
   end

   // Each leg's table feeds only that leg's converter
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
      begin
         tbl_q  <= '0;
         seen_q <= '0;
      end
      else
      begin
         for (int l = 0; l < olrv_pkg::NLEG; l++)
         begin
            if (TABLE_WR_I[l].wr)
            begin
               tbl_q[l][TABLE_WR_I[l].pt] <= TABLE_WR_I[l].code;
               seen_q[l]                  <= 1'b1;
            end
         end
      end
   end

   assign DAC_CODE_O = tbl_q;

   // Cross-compare of tables and of the delivered signal
   always_comb
   begin
      pair_ok = '1;
      loop_ok = '1;
      for (int l = 0; l < olrv_pkg::NLEG; l++)
      begin
         for (int p = 0; p < olrv_pkg::NPT; p++)
         begin
            if (!near_fn(loop_w[l][p], tbl_q[l][p], olrv_pkg::LOOP_TOL))
               loop_ok[l] = 1'b0;
            for (int m = 0; m < olrv_pkg::NLEG; m++)
               if (!near_fn(tbl_q[l][p], tbl_q[m][p], olrv_pkg::TBL_TOL))
                  pair_ok[l][m] = 1'b0;
         end
      end
   end

   // Self-diagnosis: processor, calibration, table present, no past drive fault
   assign self_ok = SELF_DIAG_OK_I & cal_ok_w & seen_q & ~drv_fault_q;

   // Two-of-three health vote; only self-healthy legs vote
   always_comb
   begin
      int unsigned cnt;
      cnt     = 0;
      healthy = '0;
      for (int m = 0; m < olrv_pkg::NLEG; m++)
      begin
         cnt = 0;
         for (int l = 0; l < olrv_pkg::NLEG; l++)
            if (self_ok[l] && pair_ok[l][m] &&
                !(drv_on_q && (drv_q == 2'(m)) && miss_bad[l]))
               cnt = cnt + 1;
         healthy[m] = self_ok[m] && (cnt >= 2);
      end
   end

   // Sample tick for loopback persistence
   assign smp_tick = (smp_q == SAMPLE_CYCLES - 1);

   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I || smp_tick)
         smp_q <= 32'h0;
      else
         smp_q <= smp_q + 32'h1;
   end

   // Miscompare persistence, restarted at each handover
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I || drv_chg)
         miss_q <= '0;
      else if (smp_tick)
      begin
         for (int l = 0; l < olrv_pkg::NLEG; l++)
         begin
            if (loop_ok[l] || !drv_on_q)
               miss_q[l] <= 8'h00;
            else if (!miss_bad[l])
               miss_q[l] <= miss_q[l] + 8'h01;
         end
      end
   end

   for (genvar g = 0; g < olrv_pkg::NLEG; g++)
   begin : g_miss
      assign miss_bad[g] = (miss_q[g] >= olrv_pkg::MISS_LIMIT);
   end

   // A driving leg voted out over its output is barred until reset
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
         drv_fault_q <= '0;
      else if (drv_on_q && !healthy[drv_q] && (|miss_bad))
         drv_fault_q[drv_q] <= 1'b1;
   end

   // Drive selection: failover, 10 s rotation, first healthy after reset
   always_comb
   begin
      drv_d    = drv_q;
      drv_on_d = drv_on_q;
      rot_d    = rot_q + 32'h1;
      if (!drv_on_q || !healthy[drv_q])
      begin
         rot_d = 32'h0;
         if (|healthy)
         begin
            drv_d    = nxt_fn(drv_q, healthy);
            drv_on_d = 1'b1;
         end
         else
            drv_on_d = 1'b0;
      end
      else if (rot_q >= ROT_CYCLES - 1)
      begin
         drv_d = nxt_fn(drv_q, healthy);
         rot_d = 32'h0;
      end
   end

   assign drv_chg = (drv_d != drv_q) || (drv_on_d != drv_on_q);

   // Drive state; reset points at C so the first search starts at A
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
      begin
         drv_q      <= 2'd2;
         drv_on_q   <= 1'b0;
         rot_q      <= 32'h0;
         NEXT_LEG_O <= 2'd0;
      end
      else
      begin
         drv_q      <= drv_d;
         drv_on_q   <= drv_on_d;
         rot_q      <= rot_d;
         NEXT_LEG_O <= nxt_fn(drv_d, healthy);
      end
   end

   // One-hot load switch; all shunt when no leg drives
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
         SWITCH_LOAD_O <= '0;
      else
         for (int l = 0; l < olrv_pkg::NLEG; l++)
            SWITCH_LOAD_O[l] <= drv_on_d && (drv_d == 2'(l));
   end

   assign DRIVE_LEG_O = drv_q;
   assign DRIVE_ON_O  = drv_on_q;

   // Fault indicator, chassis alarm follows it
   always_ff @(posedge CLOCK_I)
   begin
      if (SRST_I)
      begin
         HEALTHY_O <= '0;
         FAULT_O   <= 1'b1;
         ALARM_O   <= 1'b1;
      end
      else
      begin
         HEALTHY_O <= healthy;
         FAULT_O   <= (~&healthy) || (|miss_bad) || !drv_on_q;
         ALARM_O   <= FAULT_O;
      end
   end

endmodule : olrv_top

`default_nettype wire

// ### rtl/olrv_pkg.sv
package olrv_pkg;

   // Leg, point and code geometry
   localparam int unsigned NLEG       = 3;
   localparam int unsigned NPT        = 8;
   localparam int unsigned CW         = 16;
   localparam int unsigned PW         = 3;
   localparam int unsigned CHW        = 4;
   localparam int unsigned LW         = 2;

   // Loopback multiplexer channels: points 0..7, then two references
   localparam logic [3:0]  CH_REF_LO  = 4'h8;
   localparam logic [3:0]  CH_REF_HI  = 4'h9;
   localparam logic [3:0]  CH_LAST    = 4'h9;

   // Reference voltages as ideal converter codes
   localparam logic [15:0] REF_LO_CODE = 16'h1000;
   localparam logic [15:0] REF_HI_CODE = 16'he000;
   localparam logic [15:0] REF_SPAN    = 16'hd000;

   // Gain correction in fixed point with 14 fraction bits
   localparam int unsigned GAIN_FRAC  = 14;
   localparam logic [15:0] GAIN_MAX   = 16'hffff;
   localparam int unsigned DIV_STEPS  = 32;
   localparam logic [5:0]  DIV_LAST   = 6'h1f;

   // Tolerances, in converter codes
   localparam logic [15:0] SPAN_TOL   = 16'h0400;
   localparam logic [15:0] OFS_TOL    = 16'h0400;
   localparam logic [15:0] TBL_TOL    = 16'h0080;
   localparam logic [15:0] LOOP_TOL   = 16'h0100;

   // Timing
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned ROT_S         = 10;
   localparam int unsigned ROT_CYCLES    = ROT_S * CLK_HZ;
   localparam int unsigned SAMPLE_US     = 1000;
   localparam int unsigned SAMPLE_CYCLES = SAMPLE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FAULT_MS      = 20;
   // A quarter of the correction budget is spent confirming a miscompare
   localparam logic [7:0]  MISS_LIMIT    = 8'((FAULT_MS * 1000) / SAMPLE_US / 4);

   // Leg table write from one main processor leg
   typedef struct packed {
      logic          wr;
      logic [PW-1:0] pt;
      logic [CW-1:0] code;
   } olrv_tbl_wr_t;

   // One converter result of a leg's loopback path
   typedef struct packed {
      logic          valid;
      logic [CW-1:0] raw;
   } olrv_adc_t;

   typedef logic [NPT-1:0][CW-1:0] olrv_pts_t;

endpackage : olrv_pkg

// ### rtl/olrv_leg_mon.sv
`timescale 1ns/100ps
`default_nettype none

// Loopback scan and self-calibration of one leg
module olrv_leg_mon
(
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   srst_i,
   // Converter
   input  wire olrv_pkg::olrv_adc_t    adc_i,
   output logic [olrv_pkg::CHW-1:0]    mux_sel_o,
   // Results
   output olrv_pkg::olrv_pts_t         loop_o,
   output logic                        cal_ok_o
);

   typedef enum logic [1:0] {ST_SCAN, ST_DIV, ST_APPLY} olrv_mon_st_t;

   olrv_mon_st_t                       st_q;
   logic [olrv_pkg::CHW-1:0]           sel_q;
   logic [9:0][olrv_pkg::CW-1:0]       raw_q;
   logic [31:0]                        quo_q;
   logic [16:0]                        rem_q;
   logic [5:0]                         step_q;
   logic [olrv_pkg::CW-1:0]            span_w;
   logic [16:0]                        rem_sh;

   // Gain and offset correction of one raw reading, clamped to code range
   function automatic logic [15:0] corr_fn(input logic [15:0] raw,
                                           input logic [15:0] lo,
                                           input logic [15:0] gain);
      logic signed [33:0] t;
      t = ($signed({18'h0, raw}) - $signed({18'h0, lo})) * $signed({18'h0, gain});
      t = (t >>> olrv_pkg::GAIN_FRAC) + $signed({18'h0, olrv_pkg::REF_LO_CODE});
      if (t < 0)
         corr_fn = 16'h0000;
      else if (t > 34'sh0ffff)
         corr_fn = 16'hffff;
      else
         corr_fn = t[15:0];
   endfunction : corr_fn

   // Distance of two codes
   function automatic logic [15:0] dist_fn(input logic [15:0] a, input logic [15:0] b);
      dist_fn = (a > b) ? a - b : b - a;
   endfunction : dist_fn

   assign span_w    = raw_q[olrv_pkg::CH_REF_HI] - raw_q[olrv_pkg::CH_REF_LO];
   assign rem_sh    = {rem_q[15:0], quo_q[31]};
   assign mux_sel_o = sel_q;

   // Scan points and references, divide for gain, then apply
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         st_q     <= ST_SCAN;
         sel_q    <= 4'h0;
         raw_q    <= '0;
         quo_q    <= 32'h0;
         rem_q    <= 17'h0;
         step_q   <= 6'h0;
         loop_o   <= '0;
         cal_ok_o <= 1'b0;
      end
      else
      begin
         unique case (st_q)
            ST_SCAN:
            begin
               if (adc_i.valid)
               begin
                  raw_q[sel_q] <= adc_i.raw;
                  if (sel_q == olrv_pkg::CH_LAST)
                  begin
                     sel_q  <= 4'h0;
                     st_q   <= ST_DIV;
                     quo_q  <= {2'b00, olrv_pkg::REF_SPAN, 14'h0};
                     rem_q  <= 17'h0;
                     step_q <= 6'h0;
                  end
                  else
                     sel_q <= sel_q + 4'h1;
               end
            end
            ST_DIV:
            begin
               // Restoring division, one quotient bit per cycle
               if (rem_sh >= {1'b0, span_w})
               begin
                  rem_q <= rem_sh - {1'b0, span_w};
                  quo_q <= {quo_q[30:0], 1'b1};
               end
               else
               begin
                  rem_q <= rem_sh;
                  quo_q <= {quo_q[30:0], 1'b0};
               end
               step_q <= step_q + 6'h1;
               if (step_q == olrv_pkg::DIV_LAST)
                  st_q <= ST_APPLY;
            end
            ST_APPLY:
            begin
               for (int p = 0; p < olrv_pkg::NPT; p++)
                  loop_o[p] <= corr_fn(raw_q[p], raw_q[olrv_pkg::CH_REF_LO],
                                       (quo_q[31:16] != 16'h0) ? olrv_pkg::GAIN_MAX
                                                               : quo_q[15:0]);
               cal_ok_o <= (dist_fn(span_w, olrv_pkg::REF_SPAN) <= olrv_pkg::SPAN_TOL) &&
                           (dist_fn(raw_q[olrv_pkg::CH_REF_LO], olrv_pkg::REF_LO_CODE)
                            <= olrv_pkg::OFS_TOL);
               st_q <= ST_SCAN;
            end
         endcase
      end
   end

endmodule : olrv_leg_mon

`default_nettype wire

// ### test/olrv_monitor.sv
`timescale 1ns/100ps
`default_nettype none

// Watches switching, rotation, fault and loopback scan at the top ports
module olrv_monitor
#(
   parameter int unsigned ROT_CYCLES = 200
)
(
   // Clock and reset
   input wire logic                         CLOCK_I,
   input wire logic                         SRST_I,
   // Leg inputs and converter side
   input wire olrv_pkg::olrv_tbl_wr_t [2:0] TABLE_WR_I,
   input wire olrv_pkg::olrv_adc_t [2:0]    ADC_I,
   input wire logic [2:0][3:0]              MUX_SEL_O,
   input wire olrv_pkg::olrv_pts_t [2:0]    DAC_CODE_O,
   // Drive state and alarms
   input wire logic [2:0]                   SWITCH_LOAD_O,
   input wire logic [1:0]                   DRIVE_LEG_O,
   input wire logic                         DRIVE_ON_O,
   input wire logic [1:0]                   NEXT_LEG_O,
   input wire logic [2:0]                   HEALTHY_O,
   input wire logic                         FAULT_O,
   input wire logic                         ALARM_O
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (SRST_I);

   logic [1:0]  leg_q;
   int unsigned run_q;

   // Cycles of unchanged drive with all legs healthy
   always_ff @(posedge CLOCK_I)
   begin
      leg_q <= DRIVE_LEG_O;
      if (SRST_I || !DRIVE_ON_O || HEALTHY_O != 3'h7 || DRIVE_LEG_O != leg_q)
         run_q <= 32'h0;
      else
         run_q <= run_q + 32'h1;
   end

   a_switch_drive: assert property (
      SWITCH_LOAD_O == (DRIVE_ON_O ? 3'h1 << DRIVE_LEG_O : 3'h0))
      else $error("load switches disagree with driving leg");
   a_alarm_follow: assert property (FAULT_O != ALARM_O |=>
      ALARM_O == $past(FAULT_O))
      else $error("alarm does not follow fault indicator");
   a_drive_healthy: assert property (
      (DRIVE_ON_O && !HEALTHY_O[DRIVE_LEG_O]) [*2] |=>
      !(DRIVE_ON_O && !HEALTHY_O[DRIVE_LEG_O]))
      else $error("unhealthy leg keeps driving the load");
   a_fault_unhealthy: assert property (HEALTHY_O != 3'h7 |-> ##[0:1] FAULT_O)
      else $error("unhealthy leg without fault indicator");
   a_no_driver_fault: assert property (!DRIVE_ON_O |=> FAULT_O)
      else $error("no driving leg but fault indicator low");
   a_next_leg: assert property (
      DRIVE_ON_O && HEALTHY_O == 3'h7 && $past(HEALTHY_O, 2) == 3'h7 &&
      $past(DRIVE_LEG_O, 2) == DRIVE_LEG_O |->
      NEXT_LEG_O == (DRIVE_LEG_O == 2'h2 ? 2'h0 : DRIVE_LEG_O + 2'h1))
      else $error("next leg is not the one after the driver");
   a_rot_bound: assert property (run_q <= ROT_CYCLES + 2)
      else $error("drive duty not rotated in time");

   // Per-leg table and loopback scan checks
   for (genvar l = 0; l < 3; l++)
   begin : g_leg
      a_dac_write: assert property (TABLE_WR_I[l].wr |=>
         DAC_CODE_O[l][$past(TABLE_WR_I[l].pt)] == $past(TABLE_WR_I[l].code))
         else $error("converter code not taken from table write");
      a_mux_advance: assert property (ADC_I[l].valid && MUX_SEL_O[l] != 4'h0 &&
         MUX_SEL_O[l] != olrv_pkg::CH_LAST |=> MUX_SEL_O[l] == $past(MUX_SEL_O[l]) + 4'h1)
         else $error("loopback scan did not advance");
      a_mux_wrap: assert property (ADC_I[l].valid &&
         MUX_SEL_O[l] == olrv_pkg::CH_LAST |=> MUX_SEL_O[l] == 4'h0)
         else $error("loopback scan did not wrap after reference");
   end

endmodule : olrv_monitor

bind olrv_top olrv_monitor #(.ROT_CYCLES(ROT_CYCLES)) u_mon
(
   .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .TABLE_WR_I(TABLE_WR_I), .ADC_I(ADC_I),
   .MUX_SEL_O(MUX_SEL_O), .DAC_CODE_O(DAC_CODE_O), .SWITCH_LOAD_O(SWITCH_LOAD_O),
   .DRIVE_LEG_O(DRIVE_LEG_O), .DRIVE_ON_O(DRIVE_ON_O), .NEXT_LEG_O(NEXT_LEG_O),
   .HEALTHY_O(HEALTHY_O), .FAULT_O(FAULT_O), .ALARM_O(ALARM_O)
);

`default_nettype wire

// ### test/olrv_legs_model.sv
`timescale 1ns/100ps
`default_nettype none

// Three processor legs and the loopback converters of the load
module olrv_legs_model
(
   // Clock
   input  wire logic                        clk_i,
   // Toward the block
   output olrv_pkg::olrv_tbl_wr_t [2:0]     tbl_o,
   output logic [2:0]                       diag_ok_o,
   output olrv_pkg::olrv_adc_t [2:0]        adc_o,
   // From the block
   input  wire logic [2:0][3:0]             mux_i,
   input  wire olrv_pkg::olrv_pts_t [2:0]   dac_i,
   input  wire logic [2:0]                  sw_i
);
   logic [15:0] tbl [3][8];
   logic [2:0]  cal_err;
   logic [1:0]  bad_leg;
   logic        bad_out;
   logic [2:0]  pt_q;
   logic        ph_q;

   // Signal seen on a leg's loopback input, offset when a corrupt leg drives
   function automatic logic [15:0] reading(input int l);
      logic [15:0] v;
      v = 16'h0000;
      for (int k = 0; k < 3; k++)
         if (sw_i[k])
            v = dac_i[k][mux_i[l][2:0]] + ((bad_out && bad_leg == k) ? 16'h0800 : 16'h0000);
      if (mux_i[l] == olrv_pkg::CH_REF_LO)
         v = olrv_pkg::REF_LO_CODE;
      if (mux_i[l] == olrv_pkg::CH_REF_HI)
         v = olrv_pkg::REF_HI_CODE + (cal_err[l] ? 16'h0800 : 16'h0000);
      return v;
   endfunction : reading

   // Idle start: equal tables, legs not yet self-tested
   initial
   begin
      for (int l = 0; l < 3; l++)
         for (int p = 0; p < 8; p++)
            tbl[l][p] = 16'h2000 + 16'(p) * 16'h1000;
      cal_err = 3'h0;
      bad_leg = 2'h0;
      bad_out = 1'b0;
      pt_q = 3'h0;
      ph_q = 1'b0;
      diag_ok_o = 3'h0;
      tbl_o = '0;
      adc_o = '0;
   end

   // Each leg resends its table point by point; converters answer every other cycle
   always @(negedge clk_i)
   begin
      pt_q <= pt_q + 3'h1;
      ph_q <= !ph_q;
      for (int l = 0; l < 3; l++)
      begin
         tbl_o[l] <= '{wr: 1'b1, pt: pt_q, code: tbl[l][pt_q]};
         adc_o[l].valid <= ph_q;
         adc_o[l].raw <= ph_q ? reading(l) : ~adc_o[l].raw;
      end
   end

endmodule : olrv_legs_model

`default_nettype wire

// ### test/olrv_top_test.sv
`timescale 1ns/100ps
`default_nettype none

module olrv_top_test;
   localparam int unsigned ROT = 200;
   localparam int unsigned SMP = 40;  // Five samples must outlast two loopback scans
   localparam int unsigned FLIM = olrv_pkg::FAULT_MS * 1000 / olrv_pkg::SAMPLE_US * SMP;

   logic clk = 1'b0;
   logic srst;
   olrv_pkg::olrv_tbl_wr_t [2:0] tbl;
   logic [2:0] diag;
   olrv_pkg::olrv_adc_t [2:0] adc;
   logic [2:0][3:0] mux;
   olrv_pkg::olrv_pts_t [2:0] dac;
   logic [2:0] sw;
   logic [1:0] dleg;
   logic don;
   logic [1:0] nleg;
   logic [2:0] hlt;
   logic fault;
   logic alarm;
   int fail_count;
   int total_checks;
   int cyc = 0;

   olrv_top #(.ROT_CYCLES(ROT), .SAMPLE_CYCLES(SMP)) u_dut
   (
      .CLOCK_I(clk), .SRST_I(srst), .TABLE_WR_I(tbl), .SELF_DIAG_OK_I(diag),
      .ADC_I(adc), .MUX_SEL_O(mux), .DAC_CODE_O(dac), .SWITCH_LOAD_O(sw),
      .DRIVE_LEG_O(dleg), .DRIVE_ON_O(don), .NEXT_LEG_O(nleg), .HEALTHY_O(hlt),
      .FAULT_O(fault), .ALARM_O(alarm)
   );

   olrv_legs_model u_legs
   (
      .clk_i(clk), .tbl_o(tbl), .diag_ok_o(diag), .adc_o(adc),
      .mux_i(mux), .dac_i(dac), .sw_i(sw)
   );

   // Clock source
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         results();
      end
   end

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task results;
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   task wait_drive(input logic [1:0] leg, output int n);
      for (n = 0; n < 3000 && !(don === 1'b1 && dleg === leg); n++)
         @(negedge clk);
      chk("driving leg", 16'(leg), 16'(dleg));
   endtask : wait_drive

   task wait_hlt(input logic [2:0] h);
      for (int i = 0; i < 400 && hlt !== h; i++)
         @(negedge clk);
      chk("healthy legs", h, hlt);
   endtask : wait_hlt

   task do_reset;
      srst = 1'b1;
      repeat (4) @(negedge clk);
      chk("switches", 16'h0, sw);
      chk("fault", 16'h1, fault);
      chk("alarm", 16'h1, alarm);
      srst = 1'b0;
      u_legs.diag_ok_o = 3'h7;
   endtask : do_reset

   task t_startup;
      int n;
      wait_drive(2'h0, n);
      chk("switches", 16'h1, sw);
      chk("healthy legs", 16'h7, hlt);
      chk("next leg", 16'h1, nleg);
      repeat (2) @(negedge clk);
      chk("fault", 16'h0, fault);
      chk("alarm", 16'h0, alarm);
      for (int p = 0; p < 8; p++)
         chk("converter code", u_legs.tbl[2][p], dac[2][p]);
      $display("test startup done");
   endtask : t_startup

   task t_rotation;
      int n;
      wait_drive(2'h1, n);
      wait_drive(2'h2, n);
      chk("rotation period", 16'h1, n >= ROT - 1 && n <= ROT + 1);
      wait_drive(2'h0, n);
      chk("rotation wrap", 16'h1, n >= ROT - 1 && n <= ROT + 1);
      $display("test rotation done");
   endtask : t_rotation

   task t_skip;
      logic [1:0] d;
      logic [1:0] x;
      int n;
      d = dleg;
      x = nleg;
      u_legs.diag_ok_o[x] = 1'b0;
      wait_hlt(3'h7 & ~(3'h1 << x));
      repeat (2) @(negedge clk);
      chk("next leg", 16'(3 - d - x), nleg);
      chk("fault", 16'h1, fault);
      wait_drive(2'(3 - d - x), n);
      chk("skipped rotation", 16'h1, n <= ROT + 1);
      u_legs.diag_ok_o[x] = 1'b1;
      wait_hlt(3'h7);
      $display("test skip done");
   endtask : t_skip

   task t_drv_drop;
      logic [1:0] d;
      int n;
      d = dleg;
      u_legs.diag_ok_o[d] = 1'b0;
      for (n = 0; n < 50 && dleg === d; n++)
         @(negedge clk);
      chk("takeover leg", (d == 2'h2) ? 16'h0 : 16'(d + 2'h1), dleg);
      chk("takeover time", 16'h1, n <= 3);
      chk("switches", 16'(3'h1 << dleg), sw);
      u_legs.diag_ok_o[d] = 1'b1;
      wait_hlt(3'h7);
      $display("test driver drop done");
   endtask : t_drv_drop

   task t_bad_leg;
      logic [1:0] o;
      o = (dleg == 2'h0) ? 2'h2 : dleg - 2'h1;
      u_legs.tbl[o][5] = u_legs.tbl[o][5] + 16'h0400;
      wait_hlt(3'h7 & ~(3'h1 << o));
      chk("corrupt code", u_legs.tbl[o][5], dac[o][5]);
      chk("corrupt leg switch", 16'h0, sw[o]);
      chk("fault", 16'h1, fault);
      u_legs.tbl[o][5] = u_legs.tbl[o][5] - 16'h0400;
      wait_hlt(3'h7);
      u_legs.cal_err[o] = 1'b1;
      wait_hlt(3'h7 & ~(3'h1 << o));
      chk("calibration leg switch", 16'h0, sw[o]);
      u_legs.cal_err[o] = 1'b0;
      wait_hlt(3'h7);
      $display("test bad leg done");
   endtask : t_bad_leg

   task t_none;
      u_legs.diag_ok_o = 3'h0;
      wait_hlt(3'h0);
      repeat (2) @(negedge clk);
      chk("switches", 16'h0, sw);
      chk("drive on", 16'h0, don);
      chk("fault", 16'h1, fault);
      u_legs.diag_ok_o = 3'h7;
      wait_hlt(3'h7);
      repeat (3) @(negedge clk);
      chk("drive on", 16'h1, don);
      $display("test no healthy leg done");
   endtask : t_none

   task t_loop_fault;
      int n;
      do_reset();
      wait_drive(2'h0, n);
      u_legs.bad_leg = 2'h0;
      u_legs.bad_out = 1'b1;
      for (n = 0; n < 1000 && dleg === 2'h0; n++)
         @(negedge clk);
      chk("loop takeover time", 16'h1, n <= FLIM);
      chk("loop takeover leg", 16'h1, dleg);
      u_legs.bad_out = 1'b0;
      repeat (120) @(negedge clk);
      chk("barred leg", 16'h6, hlt);
      chk("fault", 16'h1, fault);
      $display("test loop fault done");
   endtask : t_loop_fault

   // Main sequence
   initial
   begin
      fail_count = 0;
      total_checks = 0;
      srst = 1'b1;
      do_reset();
      t_startup();
      t_rotation();
      t_skip();
      t_drv_drop();
      t_bad_leg();
      t_none();
      t_loop_fault();
      results();
   end

endmodule : olrv_top_test

`default_nettype wire
